/* hdl/srxp_pkg.sv */
// Shared receive pin block: modes, widths and pin bit positions
package srxp_pkg;

    // Port mode selected by configuration
    typedef enum logic [1:0]
    {
        SRXP_MODE_UTOPIA,
        SRXP_MODE_MII,
        SRXP_MODE_SMII,
        SRXP_MODE_SMII_SS
    } srxp_mode_e;

    // Data widths and FIFO depth
    localparam int NIBBLE_W    = 4;
    localparam int BYTE_W      = 8;
    localparam int FIFO_DEPTH  = 8;

    // Roles of the four shared pins (utopia byte bits 4 to 7)
    localparam int PIN_RX_VALID  = 0;  // utopia bit 4
    localparam int PIN_COLLISION = 1;  // utopia bit 5
    localparam int PIN_CARRIER   = 2;  // utopia bit 6
    localparam int PIN_SERIAL_RX = 3;  // utopia bit 7

    // Layout of the synchroniser vector
    localparam int SYN_PINS_LSB  = 0;
    localparam int SYN_LOW_LSB   = 4;
    localparam int SYN_MII_CLK   = 8;
    localparam int SYN_REF_CLK   = 9;
    localparam int SYN_SYNC_CLK  = 10;
    localparam int SYN_UTP_CLK   = 11;
    localparam int SYN_W         = 12;

    // Serial bit counter's last value and its first value
    localparam logic [2:0] SERIAL_LAST_BIT = 3'h7;
    localparam logic [2:0] SERIAL_FIRST    = 3'h0;

endpackage : srxp_pkg

/* hdl/srxp_fifo.sv */
// Receive byte FIFO built from flip-flops
`timescale 1ns/1ns
module srxp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX  = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_idx_q;
    logic [AW-1:0]    rd_idx_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Handshakes and honest flags
    assign in_ready  = (count_q != DEPTH_CNT);
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_idx_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Storage write
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_idx_q] <= in_data;
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
                wr_idx_q <= (wr_idx_q == LAST_IDX) ? '0 : wr_idx_q + 1'b1;
            if (pop)
                rd_idx_q <= (rd_idx_q == LAST_IDX) ? '0 : rd_idx_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end

endmodule : srxp_fifo

/* hdl/srxp_top.sv */
// Shared receive pins: utopia bits 4-7, mii status, serial mii port four
`timescale 1ns/1ns
module srxp_top
    import srxp_pkg::*;
#(
    parameter int DEPTH = srxp_pkg::FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic                         CLK,
    input  wire logic                         RESET_N,
    // Mode selection, same clock domain
    input  wire srxp_pkg::srxp_mode_e         MODE,
    // Shared pins: utopia_rx_byte bits 4 to 7
    input  wire logic [srxp_pkg::NIBBLE_W-1:0] UTOPIA_RX_BYTE_HI,
    // Low half pins: utopia_rx_byte 3:0 / mii_a_rx_nibble
    input  wire logic [srxp_pkg::NIBBLE_W-1:0] MII_A_RX_NIBBLE,
    // Link clocks, sampled as ordinary inputs
    input  wire logic                         UTOPIA_RX_CLOCK,
    input  wire logic                         MII_A_RX_CLOCK,
    input  wire logic                         SERIAL_MII_REF_CLOCK,
    input  wire logic                         SERIAL_MII_SYNC_RX_CLOCK,
    // Received byte stream
    output logic [srxp_pkg::BYTE_W-1:0]       RX_BYTE,
    output logic                              RX_BYTE_VALID,
    input  wire logic                         RX_BYTE_READY,
    // Overflow flag
    output logic                              RX_OVERFLOW,
    input  wire logic                         RX_OVERFLOW_CLEAR,
    // Mii line status
    output logic                              MII_A_COLLISION,
    output logic                              MII_A_CARRIER_SENSE
);

    logic [SYN_W-1:0]    syn1_q;
    logic [SYN_W-1:0]    syn2_q;
    logic                link_clk_s;
    logic                link_clk_prev_q;
    logic                link_rise;
    srxp_mode_e          mode_q;
    logic                mode_change;
    logic [NIBBLE_W-1:0] pins_s;
    logic [NIBBLE_W-1:0] low_s;
    logic [NIBBLE_W-1:0] nib_lo_q;
    logic                nib_phase_q;
    logic [BYTE_W-1:0]   shift_q;
    logic [2:0]          bit_cnt_q;
    logic [BYTE_W-1:0]   asm_byte_q;
    logic                asm_valid_q;
    logic                fifo_in_ready;
    logic [BYTE_W-1:0]   fifo_out_data;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [BYTE_W-1:0]   out_q;
    logic                out_valid_q;
    logic                ovf_q;
    logic                col_q;
    logic                crs_q;

    // Picks the link clock that strobes data in each mode
    function automatic logic sel_clock(input srxp_mode_e m, input logic [SYN_W-1:0] s);
        sel_clock = 1'b0;
        unique case (m)
            SRXP_MODE_UTOPIA:  sel_clock = s[SYN_UTP_CLK];
            SRXP_MODE_MII:     sel_clock = s[SYN_MII_CLK];
            SRXP_MODE_SMII:    sel_clock = s[SYN_REF_CLK];
            SRXP_MODE_SMII_SS: sel_clock = s[SYN_SYNC_CLK];
        endcase
    endfunction : sel_clock

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            syn1_q <= '0;
            syn2_q <= '0;
        end
        else
        begin
            syn1_q <= {UTOPIA_RX_CLOCK, SERIAL_MII_SYNC_RX_CLOCK, SERIAL_MII_REF_CLOCK,
                       MII_A_RX_CLOCK, MII_A_RX_NIBBLE, UTOPIA_RX_BYTE_HI};
            syn2_q <= syn1_q;
        end
    end

    assign pins_s = syn2_q[SYN_PINS_LSB +: NIBBLE_W];
    assign low_s  = syn2_q[SYN_LOW_LSB +: NIBBLE_W];

    ////////////////////////////////////////////////////////////////////////////
    // Link clock edge detection
    ////////////////////////////////////////////////////////////////////////////

    // reference clock chosen in serial mode
    // receive clock chosen in source-synchronous mode
    assign link_clk_s  = sel_clock(mode_q, syn2_q);
    assign link_rise   = link_clk_s & ~link_clk_prev_q & ~mode_change;
    assign mode_change = (MODE != mode_q);

    // Previous link clock level and current mode
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            link_clk_prev_q <= 1'b0;
            mode_q          <= SRXP_MODE_UTOPIA;
        end
        else
        begin
            link_clk_prev_q <= mode_change ? sel_clock(MODE, syn2_q) : link_clk_s;
            mode_q          <= MODE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Byte assembly per mode
    ////////////////////////////////////////////////////////////////////////////

    // Assembles bytes; partial state dropped on mode change
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            nib_lo_q    <= '0;
            nib_phase_q <= 1'b0;
            shift_q     <= '0;
            bit_cnt_q   <= SERIAL_FIRST;
            asm_byte_q  <= '0;
            asm_valid_q <= 1'b0;
        end
        else
        begin
            asm_valid_q <= 1'b0;
            if (mode_change)
            begin
                nib_phase_q <= 1'b0;
                bit_cnt_q   <= SERIAL_FIRST;
            end
            else if (link_rise)
            begin
                unique case (mode_q)
                    // pins form bits 4 to 7
                    SRXP_MODE_UTOPIA:
                    begin
                        asm_byte_q  <= {pins_s, low_s};
                        asm_valid_q <= 1'b1;
                    end
                    SRXP_MODE_MII:
                    begin
                        if (!pins_s[PIN_RX_VALID])
                            nib_phase_q <= 1'b0;
                        else if (!nib_phase_q)
                        begin
                            nib_lo_q    <= low_s;
                            nib_phase_q <= 1'b1;
                        end
                        else
                        begin
                            asm_byte_q  <= {low_s, nib_lo_q};
                            asm_valid_q <= 1'b1;
                            nib_phase_q <= 1'b0;
                        end
                    end
                    SRXP_MODE_SMII, SRXP_MODE_SMII_SS:
                    begin
                        shift_q   <= {pins_s[PIN_SERIAL_RX], shift_q[BYTE_W-1:1]};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == SERIAL_LAST_BIT)
                        begin
                            asm_byte_q  <= {pins_s[PIN_SERIAL_RX], shift_q[BYTE_W-1:1]};
                            asm_valid_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffering and output stage
    ////////////////////////////////////////////////////////////////////////////

    srxp_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .in_data   (asm_byte_q),
        .in_valid  (asm_valid_q),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    assign fifo_out_ready = ~out_valid_q | RX_BYTE_READY;

    // Registered output byte
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            out_q       <= '0;
            out_valid_q <= 1'b0;
        end
        else if (fifo_out_ready)
        begin
            // Empty slots are never loaded, so the byte stays defined
            if (fifo_out_valid)
                out_q <= fifo_out_data;
            out_valid_q <= fifo_out_valid;
        end
    end

    // Sticky overflow, set wins over clear
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            ovf_q <= 1'b0;
        else if (asm_valid_q && !fifo_in_ready)
            ovf_q <= 1'b1;
        else if (RX_OVERFLOW_CLEAR)
            ovf_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mii line status
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
        end
        else
        begin
            col_q <= (mode_q == SRXP_MODE_MII) & pins_s[PIN_COLLISION];
            crs_q <= (mode_q == SRXP_MODE_MII) & pins_s[PIN_CARRIER];
        end
    end

    assign RX_BYTE             = out_q;
    assign RX_BYTE_VALID       = out_valid_q;
    assign RX_OVERFLOW         = ovf_q;
    assign MII_A_COLLISION     = col_q;
    assign MII_A_CARRIER_SENSE = crs_q;

endmodule : srxp_top

/* tb/srxp_top_props.sv */
// Checker for the shared receive pin block
`timescale 1ns/1ns
module srxp_top_props
    import srxp_pkg::*;
#(
    parameter int DEPTH = 8
)
(
    // Clock, reset and mode
    input wire logic                 CLK,
    input wire logic                 RESET_N,
    input wire srxp_pkg::srxp_mode_e MODE,
    // Pins and link clocks
    input wire logic [3:0]           UTOPIA_RX_BYTE_HI,
    input wire logic [3:0]           MII_A_RX_NIBBLE,
    input wire logic                 UTOPIA_RX_CLOCK,
    input wire logic                 MII_A_RX_CLOCK,
    input wire logic                 SERIAL_MII_REF_CLOCK,
    input wire logic                 SERIAL_MII_SYNC_RX_CLOCK,
    // Byte stream and flags
    input wire logic [7:0]           RX_BYTE,
    input wire logic                 RX_BYTE_VALID,
    input wire logic                 RX_BYTE_READY,
    input wire logic                 RX_OVERFLOW,
    input wire logic                 RX_OVERFLOW_CLEAR,
    input wire logic                 MII_A_COLLISION,
    input wire logic                 MII_A_CARRIER_SENSE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_col_off; (MODE != SRXP_MODE_MII)[*4] |-> !MII_A_COLLISION; endproperty
    a_col_off: assert property (p_col_off) else $error("collision high outside mii");
    property p_crs_off; (MODE != SRXP_MODE_MII)[*4] |-> !MII_A_CARRIER_SENSE; endproperty
    a_crs_off: assert property (p_crs_off) else $error("carrier high outside mii");
    property p_col_fol;
        (MODE == SRXP_MODE_MII && $stable(UTOPIA_RX_BYTE_HI[1]))[*5] |-> MII_A_COLLISION == UTOPIA_RX_BYTE_HI[1];
    endproperty
    a_col_fol: assert property (p_col_fol) else $error("collision does not follow pin");
    property p_crs_fol;
        (MODE == SRXP_MODE_MII && $stable(UTOPIA_RX_BYTE_HI[2]))[*5] |-> MII_A_CARRIER_SENSE == UTOPIA_RX_BYTE_HI[2];
    endproperty
    a_crs_fol: assert property (p_crs_fol) else $error("carrier does not follow pin");
    property p_hold; RX_BYTE_VALID && !RX_BYTE_READY |=> RX_BYTE_VALID && $stable(RX_BYTE); endproperty
    a_hold: assert property (p_hold) else $error("byte lost while stalled");
    property p_ov_keep; RX_OVERFLOW && !RX_OVERFLOW_CLEAR |=> RX_OVERFLOW; endproperty
    a_ov_keep: assert property (p_ov_keep) else $error("overflow dropped by itself");
    property p_ov_clr; RX_OVERFLOW_CLEAR && !RX_BYTE_VALID |=> !RX_OVERFLOW; endproperty
    a_ov_clr: assert property (p_ov_clr) else $error("overflow not cleared");
    property p_rst; $rose(RESET_N) |-> (!RX_BYTE_VALID && !RX_OVERFLOW && RX_BYTE == 8'h00)[*4]; endproperty
    a_rst: assert property (p_rst) else $error("output active after reset");
endmodule : srxp_top_props

/* tb/srxp_phy_model.sv */
// Behavioural phy driving the shared receive pins and link clocks
`timescale 1ns/1ns
module srxp_phy_model
(
    // Shared and low half pins
    output logic [3:0] hi_pins,
    output logic [3:0] lo_pins,
    // Link clocks: utopia, mii, reference, sync; low between ticks, and idle ticks the mii clock between frames
    output logic [3:0] clks
);
    // Idle values
    initial
    begin
        hi_pins = 4'h0;
        lo_pins = 4'h0;
        clks = 4'h0;
    end

    // One period of the chosen link clock
    task automatic tick(input int sel);
        #62;
        clks[sel] = 1'b1;
        #63;
        clks[sel] = 1'b0;
    endtask : tick

    task automatic utp(input logic [7:0] b);
        {hi_pins, lo_pins} = b;
        tick(0);
    endtask : utp

    task automatic mii(input logic [7:0] b);
        hi_pins[0] = 1'b1;
        lo_pins = b[3:0];
        // serial line toggles, must be ignored
        hi_pins[3] = ~hi_pins[3];
        tick(1);
        lo_pins = b[7:4];
        tick(1);
    endtask : mii

    task automatic idle(input int n);
        repeat (n)
        begin
            hi_pins[0] = 1'b0;
            lo_pins = ~lo_pins;
            tick(1);
        end
    endtask : idle

    task automatic ser(input logic [7:0] b, input int sel);
        for (int i = 0; i < 8; i++)
        begin
            hi_pins[3] = b[i];
            tick(sel);
        end
    endtask : ser

    // Released data lines show the inverse, rx valid goes low
    task automatic rel;
        hi_pins[3] = ~hi_pins[3];
        lo_pins = ~lo_pins;
        hi_pins[0] = 1'b0;
    endtask : rel

    // carrier covers collision, falls on rx clock
    task automatic status(input logic c, input logic s);
        hi_pins[1] = c;
        if (!(c | s))
            tick(1);
        hi_pins[2] = c | s;
    endtask : status
endmodule : srxp_phy_model

/* tb/srxp_top_tb.sv */
// Testbench for the shared receive pin block
`timescale 1ns/1ns
module srxp_top_tb;
    import srxp_pkg::*;
    localparam int DEPTH = 8;
    logic       CLK = 1'b0;
    logic       RESET_N = 1'b0;
    srxp_mode_e MODE = SRXP_MODE_UTOPIA;
    logic       ready = 1'b1;
    logic       clr = 1'b0;
    logic [3:0] hi, lo, ck;
    logic [7:0] rx_byte;
    logic       rx_valid, ovf, col, crs;
    logic [7:0] rxq[$];
    logic [7:0] eq[$];
    int         bad_count = 0;
    int         n_tests = 0;

    // Clock
    always #4 CLK = ~CLK;

    srxp_phy_model phy (.hi_pins(hi), .lo_pins(lo), .clks(ck));
    srxp_top #(.DEPTH(DEPTH)) uut (.CLK(CLK), .RESET_N(RESET_N), .MODE(MODE), .UTOPIA_RX_BYTE_HI(hi),
        .MII_A_RX_NIBBLE(lo), .UTOPIA_RX_CLOCK(ck[0]), .MII_A_RX_CLOCK(ck[1]), .SERIAL_MII_REF_CLOCK(ck[2]),
        .SERIAL_MII_SYNC_RX_CLOCK(ck[3]), .RX_BYTE(rx_byte), .RX_BYTE_VALID(rx_valid), .RX_BYTE_READY(ready),
        .RX_OVERFLOW(ovf), .RX_OVERFLOW_CLEAR(clr), .MII_A_COLLISION(col), .MII_A_CARRIER_SENSE(crs));

    // Collect accepted bytes
    always @(posedge CLK)
        if (rx_valid === 1'b1 && ready === 1'b1)
            rxq.push_back(rx_byte);

    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait, then compare stream and its length
    task automatic chk_q;
        for (int i = 0; i < 4000 && rxq.size() < eq.size(); i++)
            @(negedge CLK);
        repeat (20) @(negedge CLK);
        chk(8'(rxq.size()), 8'(eq.size()));
        if (rxq.size() < eq.size())
            stop_test();
        foreach (eq[k]) chk(rxq[k], eq[k]);
        rxq.delete();
        eq.delete();
    endtask : chk_q

    task automatic set_mode(input srxp_mode_e m);
        @(negedge CLK) MODE = m;
        repeat (4) @(negedge CLK);
    endtask : set_mode

    task automatic t_utopia;
        set_mode(SRXP_MODE_UTOPIA);
        eq = '{8'h5a, 8'ha5, 8'h0f, 8'hf0};
        foreach (eq[k]) phy.utp(eq[k]);
        phy.rel();
        chk_q();
        $display("utopia test done");
    endtask : t_utopia

    task automatic t_mii;
        set_mode(SRXP_MODE_MII);
        phy.idle(3);
        phy.mii(8'h3c);
        phy.mii(8'hd2);
        phy.rel();
        eq = '{8'h3c, 8'hd2};
        chk_q();
        phy.status(1'b1, 1'b0);
        repeat (8) @(negedge CLK);
        chk({6'h00, col, crs}, 8'h03);
        phy.status(1'b0, 1'b1);
        repeat (8) @(negedge CLK);
        chk({6'h00, col, crs}, 8'h01);
        phy.status(1'b0, 1'b0);
        repeat (8) @(negedge CLK);
        chk({6'h00, col, crs}, 8'h00);
        phy.status(1'b1, 1'b1);
        $display("mii test done");
    endtask : t_mii

    task automatic t_serial;
        set_mode(SRXP_MODE_SMII);
        chk({6'h00, col, crs}, 8'h00);
        phy.ser(8'hb4, 2);
        eq = '{8'hb4};
        chk_q();
        set_mode(SRXP_MODE_SMII_SS);
        phy.ser(8'h2d, 3);
        eq = '{8'h2d};
        chk_q();
        $display("serial test done");
    endtask : t_serial

    task automatic t_fill;
        set_mode(SRXP_MODE_UTOPIA);
        ready = 1'b0;
        for (int i = 0; i < DEPTH + 3; i++)
            phy.utp(8'h31 + i[7:0]);
        for (int i = 0; i <= DEPTH; i++)
            eq.push_back(8'h31 + i[7:0]);
        repeat (10) @(negedge CLK);
        chk({7'h00, ovf}, 8'h01);
        ready = 1'b1;
        chk_q();
        chk({7'h00, rx_valid}, 8'h00);
        clr = 1'b1;
        @(negedge CLK) clr = 1'b0;
        chk({7'h00, ovf}, 8'h00);
        $display("fill test done");
    endtask : t_fill

    // Main sequence
    initial
    begin
        repeat (12) @(negedge CLK);
        RESET_N = 1'b1;
        t_utopia();
        t_mii();
        t_serial();
        t_fill();
        stop_test();
    end
endmodule : srxp_top_tb

bind srxp_top srxp_top_props #(.DEPTH(DEPTH)) u_props (.CLK(CLK), .RESET_N(RESET_N), .MODE(MODE),
    .UTOPIA_RX_BYTE_HI(UTOPIA_RX_BYTE_HI), .MII_A_RX_NIBBLE(MII_A_RX_NIBBLE), .UTOPIA_RX_CLOCK(UTOPIA_RX_CLOCK),
    .MII_A_RX_CLOCK(MII_A_RX_CLOCK), .SERIAL_MII_REF_CLOCK(SERIAL_MII_REF_CLOCK),
    .SERIAL_MII_SYNC_RX_CLOCK(SERIAL_MII_SYNC_RX_CLOCK), .RX_BYTE(RX_BYTE), .RX_BYTE_VALID(RX_BYTE_VALID),
    .RX_BYTE_READY(RX_BYTE_READY), .RX_OVERFLOW(RX_OVERFLOW), .RX_OVERFLOW_CLEAR(RX_OVERFLOW_CLEAR),
    .MII_A_COLLISION(MII_A_COLLISION), .MII_A_CARRIER_SENSE(MII_A_CARRIER_SENSE));
